// [core/sleep_standby_params.svh]
// Register offsets, field positions, reset values and timing counts of the power-down controller
`ifndef SLEEP_STANDBY_PARAMS_SVH
`define SLEEP_STANDBY_PARAMS_SVH
// Register byte offsets
`define SSC_OFF_STBYCR 8'h00
`define SSC_OFF_INTCR1 8'h04
`define SSC_OFF_WDTCSR 8'h08
`define SSC_OFF_WDTRST 8'h0c
`define SSC_OFF_WDTCNT 8'h10
`define SSC_OFF_STATUS 8'h14
// Field positions
`define SSC_BIT_STBY_SEL 0
`define SSC_BIT_NMI_EDGE 0
`define SSC_BIT_WDT_OVF 7
`define SSC_BIT_MODE 6
`define SSC_BIT_WDT_EN 5
`define SSC_CKS_HI 2
`define SSC_CKS_LO 0
// Reset values
`define SSC_RST_STBY_SEL 1'b0
`define SSC_RST_NMI_EDGE 1'b0
`define SSC_RST_WDTCSR 8'h00
`define SSC_RST_WDTRST 8'h00
`define SSC_RST_WDTCNT 8'h00
// Acknowledge hold after standby exit, in half external bus clock cycles
`define SSC_ACK_HOLD_HALVES 3
// Master clock cycles per external bus clock cycle
`define SSC_CKE_DIV 4
`endif

// [core/sleep_standby_pkg.sv]
// Types shared by the power-down controller
package sleep_standby_pkg;
   typedef enum logic [5:0] {
      ST_RUN    = 6'b000001,
      ST_SLEEP  = 6'b000010,
      ST_SSTBY  = 6'b000100,
      ST_WAKE   = 6'b001000,
      ST_POR    = 6'b010000,
      ST_HWSTBY = 6'b100000
   } pwr_state_t;
endpackage : sleep_standby_pkg

// [core/sleep_standby_ctrl.sv]
// Sleep and software standby controller with watchdog-timed wake-up and bus release handshake
`include "sleep_standby_params.svh"

// Operation
// - Sleep instruction with standby select clear enters sleep, CPU halted, registers kept.
// - In sleep peripherals keep running and both clock output pins keep toggling.
// - In sleep no new external bus release request is granted.
// - Unmasked NMI, external or enabled peripheral interrupt ends sleep, starts handling.
// - DMA address error during sleep ends sleep and starts its exception handling.
// - Low power-on reset pin during sleep enters the power-on reset state.
// - Low hardware standby pin moves the device into hardware standby.
// - Sleep instruction with standby select set enters standby, stops clocks and outputs.
// - Standby keeps retained registers and pulses initialisation of the other units.
// - Standby entry clears watchdog flag, mode, enable, reset control; keeps select, counter.
// - In standby the external bus floats, DRAM control stays, bus request ignored.
// - Standby entered while released drives the acknowledge high, bus still floating.
// - Exit after released entry: request still on keeps released, else normal ownership.
// - Standby from normal ownership floats acknowledge; exit without request drives it high.
// - Exit from normal entry with request on holds acknowledge high 1.5 bus clocks.
// - NMI edge select bit picks falling edge at 0, rising edge at 1.
// - NMI edge in standby restarts oscillator, clocks watchdog only; overflow resumes chip.
// - Low power-on reset pin leaves standby into reset; driver holds it until settled.
module sleep_standby_ctrl #(
   parameter int CKE_DIV = `SSC_CKE_DIV,
   parameter int AW = 8
) (
   // Clock, reset, enable
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   // APB register port
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // CPU and interrupt sources
   input wire logic SLEEP_EXEC,
   input wire logic EXT_INT_REQ,
   input wire logic [3:0] EXT_INT_LEVEL,
   input wire logic PERIPH_INT_REQ,
   input wire logic PERIPH_INT_EN,
   input wire logic [3:0] PERIPH_INT_LEVEL,
   input wire logic [3:0] CPU_STATUS_MASK,
   input wire logic NMI_PIN,
   input wire logic DMA_ADDR_ERR,
   // Reset and standby pins
   input wire logic POWER_ON_RESET_PIN_N,
   input wire logic HW_STANDBY_PIN_N,
   // External bus release
   input wire logic BUS_RELEASE_REQUEST_N,
   output logic BUS_ACK_N_O,
   output logic BUS_ACK_N_OE,
   output logic EXT_BUS_OE,
   output logic DRAM_CTRL_OE,
   // Clock and module control
   output logic CPU_CLK_EN,
   output logic PERIPH_CLK_EN,
   output logic WDT_CLK_EN,
   output logic OSC_EN,
   output logic BUS_CLOCK_OUT_EN,
   output logic SYSTEM_CLOCK_OUT_EN,
   // Events and state
   output logic PERIPH_INIT,
   output logic INT_EXC_START,
   output logic DMA_ERR_EXC_START,
   output logic POR_ACTIVE,
   output logic HW_STANDBY_ACTIVE
);

   localparam int HOLD_INT = (`SSC_ACK_HOLD_HALVES * CKE_DIV + 1) / 2;
   localparam logic [7:0] HOLD_CYC = HOLD_INT[7:0];

   // Divide-by-two-to-the-(select+1) prescaler tick
   function automatic logic presc_tick(input logic [15:0] presc, input logic [2:0] cks);
      logic [15:0] mask;
      mask = (16'h0002 << cks) - 16'h0001;
      return (presc & mask) == mask;
   endfunction : presc_tick

   sleep_standby_pkg::pwr_state_t state_q, state_d;
   logic stby_sel_q, nmi_edge_sel_q;
   logic [7:0] csr_q, wdt_rst_ctrl_q, cnt_q;
   logic [15:0] presc_q;
   logic nmi_prev_q;
   logic released_q, released_d;
   logic from_rel_q, from_rel_d;
   logic [7:0] hold_q, hold_d;
   logic int_exc_q, int_exc_d, dma_exc_q, dma_exc_d, init_q, init_d;
   logic [31:0] rdata_q;

   // State decode
   wire st_run = state_q == sleep_standby_pkg::ST_RUN;
   wire st_sleep = state_q == sleep_standby_pkg::ST_SLEEP;
   wire st_sstby = state_q == sleep_standby_pkg::ST_SSTBY;
   wire st_wake = state_q == sleep_standby_pkg::ST_WAKE;
   wire st_por = state_q == sleep_standby_pkg::ST_POR;
   wire st_hw = state_q == sleep_standby_pkg::ST_HWSTBY;
   wire standby = st_sstby | st_wake;
   wire req_act = ~BUS_RELEASE_REQUEST_N;
   wire pins_ok = POWER_ON_RESET_PIN_N & HW_STANDBY_PIN_N;

   // Wake sources
   wire ext_ok = EXT_INT_REQ & (EXT_INT_LEVEL > CPU_STATUS_MASK);
   wire per_ok = PERIPH_INT_REQ & PERIPH_INT_EN & (PERIPH_INT_LEVEL > CPU_STATUS_MASK);
   wire nmi_edge = nmi_edge_sel_q ? (NMI_PIN & ~nmi_prev_q) : (~NMI_PIN & nmi_prev_q);
   wire int_accept = nmi_edge | ext_ok | per_ok;

   // Watchdog counting and overflow
   wire [2:0] cks = csr_q[`SSC_CKS_HI:`SSC_CKS_LO];
   wire wdt_run = st_wake | ((st_run | st_sleep) & csr_q[`SSC_BIT_WDT_EN]);
   wire wdt_tick = wdt_run & presc_tick(presc_q, cks);
   wire wdt_ovf = wdt_tick & (cnt_q == 8'hff);
   wire enter_sstby = st_run & pins_ok & SLEEP_EXEC & stby_sel_q;
   wire wake_done = st_wake & pins_ok & wdt_ovf;

   // APB decode
   wire acc = PSEL & PENABLE & CE;
   wire wr = acc & PWRITE;
   wire hit_stby = PADDR == `SSC_OFF_STBYCR;
   wire hit_icr = PADDR == `SSC_OFF_INTCR1;
   wire hit_csr = PADDR == `SSC_OFF_WDTCSR;
   wire hit_rst = PADDR == `SSC_OFF_WDTRST;
   wire hit_cnt = PADDR == `SSC_OFF_WDTCNT;
   wire hit_sts = PADDR == `SSC_OFF_STATUS;
   wire hit = hit_stby | hit_icr | hit_csr | hit_rst | hit_cnt | hit_sts;
   wire [31:0] status_w = {21'h000000, state_q, hold_q != 8'h00, from_rel_q, released_q, BUS_ACK_N_O, EXT_BUS_OE};
   wire [31:0] rd_mux = hit_stby ? {31'h00000000, stby_sel_q} :
                        hit_icr ? {31'h00000000, nmi_edge_sel_q} :
                        hit_csr ? {24'h000000, csr_q} :
                        hit_rst ? {24'h000000, wdt_rst_ctrl_q} :
                        hit_cnt ? {24'h000000, cnt_q} :
                        hit_sts ? status_w : 32'h00000000;
   assign PREADY = CE;
   assign PSLVERR = acc & ~hit;
   assign PRDATA = rdata_q;

   // Mode sequencing; the standby pin wins over the reset pin
   always_comb begin
      state_d = state_q;
      int_exc_d = 1'b0;
      dma_exc_d = 1'b0;
      init_d = 1'b0;
      if (!HW_STANDBY_PIN_N) begin
         state_d = sleep_standby_pkg::ST_HWSTBY;
      end else if (!POWER_ON_RESET_PIN_N) begin
         state_d = sleep_standby_pkg::ST_POR;
      end else begin
         case (state_q)
            sleep_standby_pkg::ST_RUN: begin
               if (SLEEP_EXEC && stby_sel_q) begin
                  state_d = sleep_standby_pkg::ST_SSTBY;
                  init_d = 1'b1;
               end else if (SLEEP_EXEC) begin
                  state_d = sleep_standby_pkg::ST_SLEEP;
               end
            end
            sleep_standby_pkg::ST_SLEEP: begin
               if (int_accept) begin
                  state_d = sleep_standby_pkg::ST_RUN;
                  int_exc_d = 1'b1;
               end else if (DMA_ADDR_ERR) begin
                  state_d = sleep_standby_pkg::ST_RUN;
                  dma_exc_d = 1'b1;
               end
            end
            sleep_standby_pkg::ST_SSTBY: begin
               if (nmi_edge) begin
                  state_d = sleep_standby_pkg::ST_WAKE;
               end
            end
            sleep_standby_pkg::ST_WAKE: begin
               if (wdt_ovf) begin
                  state_d = sleep_standby_pkg::ST_RUN;
                  int_exc_d = 1'b1;
               end
            end
            sleep_standby_pkg::ST_POR: state_d = sleep_standby_pkg::ST_RUN;
            sleep_standby_pkg::ST_HWSTBY: state_d = sleep_standby_pkg::ST_POR;
            default: state_d = sleep_standby_pkg::ST_POR;
         endcase
      end
   end

   // Bus release ownership across sleep and standby
   always_comb begin
      released_d = released_q;
      from_rel_d = from_rel_q;
      hold_d = hold_q;
      if (st_por | st_hw | ~pins_ok) begin
         released_d = 1'b0;
         from_rel_d = 1'b0;
         hold_d = 8'h00;
      end else if (enter_sstby) begin
         from_rel_d = released_q;
      end else if (wake_done) begin
         if (from_rel_q) begin
            released_d = req_act;
         end else if (req_act) begin
            released_d = 1'b0;
            hold_d = HOLD_CYC;
         end else begin
            released_d = 1'b0;
         end
         from_rel_d = 1'b0;
      end else if (st_sleep) begin
         released_d = released_q & req_act;
      end else if (st_run && hold_q != 8'h00) begin
         hold_d = hold_q - 8'h01;
         released_d = hold_q == 8'h01;
      end else if (st_run) begin
         released_d = req_act;
      end
   end

   // Pin and clock controls decoded from the mode; bus pins also use the release flags
   assign BUS_ACK_N_OE = ~st_hw & ~(standby & ~from_rel_q);
   assign BUS_ACK_N_O = standby | ~released_q;
   assign EXT_BUS_OE = ~(standby | st_hw | released_q);
   assign DRAM_CTRL_OE = ~st_hw;
   assign CPU_CLK_EN = st_run | st_por;
   assign PERIPH_CLK_EN = st_run | st_sleep;
   assign WDT_CLK_EN = st_run | st_sleep | st_wake;
   assign OSC_EN = ~st_sstby & ~st_hw;
   assign BUS_CLOCK_OUT_EN = st_run | st_sleep | st_por;
   assign SYSTEM_CLOCK_OUT_EN = st_run | st_sleep | st_por;
   assign PERIPH_INIT = init_q;
   assign INT_EXC_START = int_exc_q;
   assign DMA_ERR_EXC_START = dma_exc_q;
   assign POR_ACTIVE = st_por;
   assign HW_STANDBY_ACTIVE = st_hw;

   // Mode, handshake and event flops
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_q <= sleep_standby_pkg::ST_POR;
         released_q <= 1'b0;
         from_rel_q <= 1'b0;
         hold_q <= 8'h00;
         int_exc_q <= 1'b0;
         dma_exc_q <= 1'b0;
         init_q <= 1'b0;
         nmi_prev_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else if (CE) begin
         state_q <= state_d;
         released_q <= released_d;
         from_rel_q <= from_rel_d;
         hold_q <= hold_d;
         int_exc_q <= int_exc_d;
         dma_exc_q <= dma_exc_d;
         init_q <= init_d;
         nmi_prev_q <= NMI_PIN;
         if (PSEL && !PENABLE) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Standby and interrupt control bits; reset state clears them
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         stby_sel_q <= `SSC_RST_STBY_SEL;
         nmi_edge_sel_q <= `SSC_RST_NMI_EDGE;
         wdt_rst_ctrl_q <= `SSC_RST_WDTRST;
      end else if (CE) begin
         if (st_por | st_hw) begin
            stby_sel_q <= `SSC_RST_STBY_SEL;
            nmi_edge_sel_q <= `SSC_RST_NMI_EDGE;
            wdt_rst_ctrl_q <= `SSC_RST_WDTRST;
         end else if (enter_sstby) begin
            wdt_rst_ctrl_q <= `SSC_RST_WDTRST;
         end else begin
            if (wr && hit_stby) stby_sel_q <= PWDATA[`SSC_BIT_STBY_SEL];
            if (wr && hit_icr) nmi_edge_sel_q <= PWDATA[`SSC_BIT_NMI_EDGE];
            if (wr && hit_rst) wdt_rst_ctrl_q <= PWDATA[7:0];
         end
      end
   end

   // Watchdog control, counter and prescaler; overflow set beats a software clear
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         csr_q <= `SSC_RST_WDTCSR;
         cnt_q <= `SSC_RST_WDTCNT;
         presc_q <= 16'h0000;
      end else if (CE) begin
         if (st_por | st_hw) begin
            csr_q <= `SSC_RST_WDTCSR;
            cnt_q <= `SSC_RST_WDTCNT;
            presc_q <= 16'h0000;
         end else if (enter_sstby) begin
            csr_q[`SSC_BIT_WDT_OVF] <= 1'b0;
            csr_q[`SSC_BIT_MODE] <= 1'b0;
            csr_q[`SSC_BIT_WDT_EN] <= 1'b0;
         end else begin
            if (wdt_run) presc_q <= presc_q + 16'h0001;
            if (wr && hit_csr) begin
               csr_q[6:0] <= PWDATA[6:0];
               csr_q[`SSC_BIT_WDT_OVF] <= (csr_q[`SSC_BIT_WDT_OVF] & PWDATA[`SSC_BIT_WDT_OVF]) | (wdt_ovf & ~st_wake);
            end else if (wdt_ovf && !st_wake) begin
               csr_q[`SSC_BIT_WDT_OVF] <= 1'b1;
            end
            if (wr && hit_cnt) begin
               cnt_q <= PWDATA[7:0];
            end else if (wdt_tick) begin
               cnt_q <= cnt_q + 8'h01;
            end
         end
      end
   end

   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   chk_sleep_entry: assert property (CE && enter_sstby == 1'b0 && st_run && pins_ok && SLEEP_EXEC
      && !stby_sel_q |=> st_sleep && !CPU_CLK_EN) else $error("sleep not entered");
   chk_sleep_clocks: assert property (st_sleep |-> PERIPH_CLK_EN && BUS_CLOCK_OUT_EN
      && SYSTEM_CLOCK_OUT_EN) else $error("clocks stopped in sleep");
   chk_sleep_no_grant: assert property (CE && st_sleep && !released_q |=> !released_q)
      else $error("bus granted in sleep");
   chk_int_wake_sleep: assert property (CE && st_sleep && pins_ok && int_accept
      |=> st_run && INT_EXC_START) else $error("interrupt did not end sleep");
   chk_dma_wake_sleep: assert property (CE && st_sleep && pins_ok && !int_accept && DMA_ADDR_ERR
      |=> st_run && DMA_ERR_EXC_START) else $error("dma error did not end sleep");
   chk_pin_resets: assert property (CE && HW_STANDBY_PIN_N && !POWER_ON_RESET_PIN_N |=> POR_ACTIVE)
      else $error("reset pin ignored");
   chk_hw_standby: assert property (CE && !HW_STANDBY_PIN_N |=> HW_STANDBY_ACTIVE && !EXT_BUS_OE)
      else $error("standby pin ignored");
   chk_sstby_entry: assert property (CE && enter_sstby |=> st_sstby && PERIPH_INIT && !OSC_EN
      && !BUS_CLOCK_OUT_EN && !SYSTEM_CLOCK_OUT_EN && !PERIPH_CLK_EN) else $error("bad standby entry");
   chk_wdt_entry_clear: assert property (CE && enter_sstby |=> csr_q[7:5] == 3'b000
      && wdt_rst_ctrl_q == 8'h00 && $stable(cnt_q) && $stable(csr_q[2:0]))
      else $error("watchdog bits not handled");
   chk_bus_float: assert property (standby |-> !EXT_BUS_OE && BUS_ACK_N_OE == from_rel_q
      && BUS_ACK_N_O) else $error("bus not floating");
   chk_rel_exit: assert property (CE && wake_done && from_rel_q |=> released_q == $past(req_act)
      && BUS_ACK_N_O == !$past(req_act)) else $error("bad exit from released");
   chk_ack_hold: assert property (CE && wake_done && !from_rel_q && req_act |=> hold_q == HOLD_CYC
      && BUS_ACK_N_OE && BUS_ACK_N_O) else $error("acknowledge hold not started");
   chk_hold_high: assert property (st_run && hold_q != 8'h00 |-> BUS_ACK_N_O && BUS_ACK_N_OE)
      else $error("acknowledge dropped during hold");
   chk_nmi_wake: assert property (CE && st_sstby && pins_ok && nmi_edge |=> st_wake && WDT_CLK_EN
      && !CPU_CLK_EN) else $error("nmi edge did not wake");
   chk_wake_done: assert property (CE && wake_done |=> st_run && INT_EXC_START)
      else $error("overflow did not resume");

   cov_sleep_int: cover property (st_sleep ##1 INT_EXC_START);
   cov_nmi_wake: cover property (st_sstby ##1 st_wake ##[1:1000] st_run);
   cov_ack_hold: cover property (hold_q == 8'h01 ##1 released_q);
endmodule : sleep_standby_ctrl

// [dv/bus_master_model.sv]
// Far-side model: external bus requester and NMI source of the power-down controller
module bus_master_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Commands from the bench
   input wire logic req_on,
   input wire logic edge_sel,
   input wire logic wake,
   input wire logic handling_started,
   // Pins towards the device
   output logic req_n,
   output logic nmi
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wake_q;

   // Wake level is latched and kept until exception handling has started
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_q <= 1'h0;
      end else if (handling_started) begin
         wake_q <= 1'h0;
      end else if (wake) begin
         wake_q <= 1'h1;
      end
   end

   // Opposite of the wake edge while idle, wake level once woken
   assign nmi = wake_q ? edge_sel : !edge_sel;
   assign req_n = !req_on;
endmodule : bus_master_model

// [dv/sleep_standby_power_control_tb_top.sv]
// Self-checking bench for the sleep and software standby controller
module sleep_standby_power_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, slp = 1'h0;
   logic eir = 1'h0, pir = 1'h0, pie = 1'h0, dma = 1'h0, por_n = 1'h1, hw_n = 1'h1;
   logic req_on = 1'h0, nsel = 1'h0, wake = 1'h0, ce = 1'h1;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [3:0] eil = 4'h0, pil = 4'h9, mask = 4'h3;
   logic pready, pslverr, e, nmi, req_n, ack_o, ack_oe, bus_oe, dram_oe, cpu_en, per_en;
   logic wdt_en, osc_en, bco, sco, pinit, iexc, dexc, por, hws;
   int num_errors = 0, cmp_count = 0, cyc = 0, k;

   // Clock at 250 MHz
   always #2 mclk = ~mclk;

   sleep_standby_ctrl sleep_standby_ctrl_inst (
      .MCLK(mclk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SLEEP_EXEC(slp), .EXT_INT_REQ(eir), .EXT_INT_LEVEL(eil), .PERIPH_INT_REQ(pir),
      .PERIPH_INT_EN(pie), .PERIPH_INT_LEVEL(pil), .CPU_STATUS_MASK(mask), .NMI_PIN(nmi),
      .DMA_ADDR_ERR(dma), .POWER_ON_RESET_PIN_N(por_n), .HW_STANDBY_PIN_N(hw_n),
      .BUS_RELEASE_REQUEST_N(req_n), .BUS_ACK_N_O(ack_o), .BUS_ACK_N_OE(ack_oe),
      .EXT_BUS_OE(bus_oe), .DRAM_CTRL_OE(dram_oe), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en),
      .WDT_CLK_EN(wdt_en), .OSC_EN(osc_en), .BUS_CLOCK_OUT_EN(bco), .SYSTEM_CLOCK_OUT_EN(sco),
      .PERIPH_INIT(pinit), .INT_EXC_START(iexc), .DMA_ERR_EXC_START(dexc), .POR_ACTIVE(por),
      .HW_STANDBY_ACTIVE(hws));

   bus_master_model bus_master_model_inst (.clk(mclk), .rst(rst), .req_on(req_on),
      .edge_sel(nsel), .wake(wake), .handling_started(iexc), .req_n(req_n), .nmi(nmi));

   task chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
         num_errors++;
      end
   endtask : chk

   // One APB transfer, held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      pen <= 1'h1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask : apb

   task rd_chk(input logic [7:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk(r, x);
   endtask : rd_chk

   task sleep_go;
      @(posedge mclk);
      slp <= 1'h1;
      @(posedge mclk);
      slp <= 1'h0;
      @(negedge mclk);
   endtask : sleep_go

   // Pull the reset pin or the standby pin, then release both
   task pin_exit(input logic hw);
      @(posedge mclk);
      por_n <= hw;
      hw_n <= !hw;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk({por, hws}, {!hw, hw});
      repeat (4) @(posedge mclk);
      por_n <= 1'h1;
      hw_n <= 1'h1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({por, hws, cpu_en}, 3'h1);
   endtask : pin_exit

   // Standby entry from released or owned bus, then exit by NMI (0), reset pin (1) or standby pin (2)
   task sby_cycle(input logic ns, input logic rl, input logic rq, input int ex);
      int n;
      @(posedge mclk);
      nsel <= ns;
      req_on <= rl;
      apb(1'h1, 8'h04, {31'h0, ns});
      apb(1'h1, 8'h00, 32'h1);
      apb(1'h1, 8'h08, 32'h42);
      apb(1'h1, 8'h0c, 32'h5a);
      apb(1'h1, 8'h10, 32'hfc);
      chk(ack_o, !rl);
      sleep_go;
      chk({pinit, cpu_en, per_en, osc_en, bco, sco, bus_oe, dram_oe}, 8'h81);
      chk({ack_oe, ack_o & rl}, {rl, rl});
      @(posedge mclk);
      req_on <= !rl;
      rd_chk(8'h08, 32'h02);
      rd_chk(8'h0c, 32'h0);
      rd_chk(8'h10, 32'hfc);
      rd_chk(8'h00, 32'h1);
      chk({ack_oe, bus_oe}, {rl, 1'h0});
      @(posedge mclk);
      req_on <= rq;
      if (ex == 0) begin
         @(posedge mclk);
         wake <= 1'h1;
         @(posedge mclk);
         wake <= 1'h0;
         n = 0;
         while (wdt_en !== 1'h1 && n < 10) begin
            @(negedge mclk);
            n++;
         end
         chk({wdt_en, osc_en, cpu_en, per_en}, 4'hc);
         n = 0;
         while (iexc !== 1'h1 && n < 300) begin
            @(negedge mclk);
            n++;
         end
         chk(iexc, 1'h1);
         chk({ack_oe, ack_o, bus_oe}, (rl && rq) ? 3'h4 : 3'h7);
         if (!rl && rq) begin
            n = 0;
            while (ack_o !== 1'h0 && n < 20) begin
               @(negedge mclk);
               n++;
            end
            chk(n, 32'h6);
         end
      end else begin
         pin_exit(ex == 2);
      end
      @(posedge mclk);
      req_on <= 1'h0;
      repeat (4) @(posedge mclk);
   endtask : sby_cycle

   task final_report;
      $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   // Cuts a hang short
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 8000) begin
         num_errors++;
         final_report;
      end
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge mclk);
      rst <= 1'h0;
      for (k = 0; k < 5; k++) begin
         rd_chk(8'(4 * k), 32'h0);
      end
      apb(1'h1, 8'h14, 32'hffffffff);
      rd_chk(8'h14, 32'h23);
      apb(1'h0, 8'h18, 32'h0);
      chk(e, 1'h1);
      chk(r, 32'h0);
      sleep_go;
      chk({cpu_en, per_en, bco, sco}, 4'h7);
      rd_chk(8'h14, 32'h43);
      @(posedge mclk);
      req_on <= 1'h1;
      eir <= 1'h1;
      eil <= 4'h3;
      pir <= 1'h1;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk({ack_o, cpu_en}, 2'h2);
      // Clock enable low freezes sleep against an acceptable interrupt
      @(posedge mclk);
      ce <= 1'h0;
      eil <= 4'h5;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({iexc, cpu_en}, 2'h0);
      @(posedge mclk);
      ce <= 1'h1;
      eil <= 4'h3;
      // Each wake cause in turn: external, enabled peripheral, DMA address error
      for (k = 0; k < 3; k++) begin
         if (k > 0) begin
            sleep_go;
         end
         @(posedge mclk);
         req_on <= 1'h0;
         eir <= (k == 0);
         eil <= 4'h5;
         pir <= (k == 1);
         pie <= (k == 1);
         dma <= (k == 2);
         @(posedge mclk);
         @(negedge mclk);
         chk({iexc, dexc, cpu_en}, (k == 2) ? 3'h3 : 3'h5);
         @(posedge mclk);
         eir <= 1'h0;
         pir <= 1'h0;
         pie <= 1'h0;
         dma <= 1'h0;
      end
      sleep_go;
      pin_exit(1'h0);
      sleep_go;
      pin_exit(1'h1);
      sby_cycle(1'h1, 1'h0, 1'h1, 0);
      sby_cycle(1'h0, 1'h1, 1'h1, 0);
      sby_cycle(1'h1, 1'h1, 1'h0, 0);
      sby_cycle(1'h1, 1'h0, 1'h0, 0);
      sby_cycle(1'h0, 1'h0, 1'h0, 1);
      sby_cycle(1'h1, 1'h0, 1'h0, 2);
      final_report;
   end
endmodule : sleep_standby_power_control_tb_top
